/* File: port_select_pkg.sv */
// constants for the converter output port block
package port_select_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int RESULT_W = 16;
	localparam int CHANNELS = 6;
	localparam int STREAM_W = 48;
	localparam int PIN_W = 20;
	// result registers, one per channel, then status
	localparam logic [7:0] ADDR_RESULT_A0 = 8'h00;
	localparam logic [7:0] ADDR_RESULT_A1 = 8'h04;
	localparam logic [7:0] ADDR_RESULT_B0 = 8'h08;
	localparam logic [7:0] ADDR_RESULT_B1 = 8'h0C;
	localparam logic [7:0] ADDR_RESULT_C0 = 8'h10;
	localparam logic [7:0] ADDR_RESULT_C1 = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// shared bus line positions
	localparam int LINE_CHAIN_EN = 7;
	localparam int LINE_BYTE_ORDER = 7;
	localparam int LINE_SCLK = 6;
	localparam int LINE_CHAIN_A = 5;
	localparam int LINE_CHAIN_B = 4;
	localparam int LINE_CHAIN_C = 3;
	localparam int LINE_SEL_C = 2;
	localparam int LINE_SEL_B = 1;
	localparam int LINE_SEL_A = 0;
	localparam int LINE_OUT_C = 10;
	localparam int LINE_OUT_B = 9;
	localparam int LINE_OUT_A = 8;
	// synchronised pin vector: {rd_n, cs_fs_n, word_byte, interface, bus[15:0]}
	localparam int PIN_RD = 19;
	localparam int PIN_FS = 18;
	localparam int PIN_WORD_BYTE = 17;
	localparam int PIN_IFACE = 16;
	localparam logic [19:0] PIN_RESET = 20'hC_0000;
	localparam logic [15:0] OE_WORD = 16'hFFFF;
	localparam logic [15:0] OE_BYTE = 16'hFF00;
	localparam logic [2:0] LAST_CHANNEL = 3'h5;
	typedef enum logic [2:0] {
		LINK_IDLE = 3'b001,
		LINK_PAR = 3'b010,
		LINK_SER = 3'b100
	} link_state_type;
endpackage : port_select_pkg

/* File: pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 20,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	// stage1 feeds only stage2; a change counts once stage2 and stage3 agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
			level <= RESET_VALUE;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	end
endmodule : pin_sync

/* File: adc_output_port_select.sv */
// converter output port: strap-selected parallel and serial result paths
// Function
// (R1) byte mode, byte order strap high: upper half of result out first on lines 15:8.
// (R2) byte mode, byte order strap low: lower half of result out first on lines 15:8.
// (R3) serial with chaining: line 5 is the chained input behind pair A's stream.
// (R4) line 4 chains into pair B only when pair-B select and chaining are high.
// (R5) line 3 chains into pair C only when pair-C select and chaining are high.
// (R6) serial: pair-C output enabled by its select strap, disabled when low.
// (R7) serial: pair-B output enabled by its select strap, disabled when low.
// (R8) word mode: shared lines 0 to 7 are ordinary bidirectional data bits.
// (R9) host drives serial clock on line 6; device shifts with it.
// (R10) interface strap low picks parallel, high picks serial; sets every shared pin.
// (R11) pair-C select low: pair C data also follow on pair-B serial output.
// (R12) host keeps pair-A select high so pair-A output stays active.
// (R13) byte mode: second half of result appears on the next read strobe.
`timescale 1ns/10ps
module adc_output_port_select (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic interface_type_strap,
	input wire logic word_byte_strap,
	input wire logic frame_select_n,
	input wire logic read_strobe_n,
	input wire logic [15:0] parallel_bus_line_in,
	output logic [15:0] parallel_bus_line_out,
	output logic [15:0] parallel_bus_line_oe
);
	logic [19:0] pins;
	logic [15:0] result [port_select_pkg::CHANNELS];
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	port_select_pkg::link_state_type link_state;
	port_select_pkg::link_state_type next_link_state;
	logic [2:0] read_index;
	logic second_half;
	logic sclk_prev;
	logic rd_prev;
	logic fs_prev;
	logic [47:0] stream_a;
	logic [47:0] stream_b;
	logic [47:0] stream_c;

	pin_sync #(.WIDTH(port_select_pkg::PIN_W), .RESET_VALUE(port_select_pkg::PIN_RESET)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({read_strobe_n, frame_select_n, word_byte_strap, interface_type_strap,
			parallel_bus_line_in}),
		.level(pins)
	);

	function automatic logic [2:0] chan_of(input logic [7:0] addr);
		chan_of = addr[4:2];
	endfunction : chan_of

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr[1:0] == 2'b00) && (addr <= port_select_pkg::ADDR_RESULT_C1);
	endfunction : mapped

	// shared pin meanings
	wire serial_sel = pins[port_select_pkg::PIN_IFACE]; // [R10]
	wire byte_mode = pins[port_select_pkg::PIN_WORD_BYTE];
	wire fs_n = pins[port_select_pkg::PIN_FS];
	wire rd_n = pins[port_select_pkg::PIN_RD];
	wire byte_order_strap = pins[port_select_pkg::LINE_BYTE_ORDER];
	wire chain_enable_strap = pins[port_select_pkg::LINE_CHAIN_EN];
	wire sel_a = pins[port_select_pkg::LINE_SEL_A];
	wire sel_b = pins[port_select_pkg::LINE_SEL_B];
	wire sel_c = pins[port_select_pkg::LINE_SEL_C];
	wire serial_clock = pins[port_select_pkg::LINE_SCLK]; // [R9]
	wire chain_in_pair_a = chain_enable_strap & pins[port_select_pkg::LINE_CHAIN_A]; // [R3]
	wire chain_in_pair_b = chain_enable_strap & sel_b & pins[port_select_pkg::LINE_CHAIN_B]; // [R4]
	wire chain_in_pair_c = chain_enable_strap & sel_c & pins[port_select_pkg::LINE_CHAIN_C]; // [R5]
	wire sclk_fall = sclk_prev && !serial_clock;
	wire frame_start = fs_prev && !fs_n;
	wire rd_rise = !rd_prev && rd_n;
	wire par_read = (link_state == port_select_pkg::LINK_PAR) && !fs_n && !rd_n;
	wire [15:0] cur_word = result[read_index];
	wire show_high = byte_order_strap ^ second_half; // [R1] [R2]
	wire [7:0] cur_byte = show_high ? cur_word[15:8] : cur_word[7:0];

	// register bus: write address and data taken in either order
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] status_word = {20'h0_0000, second_half, read_index, chain_enable_strap, sel_c,
		sel_b, sel_a, byte_order_strap, byte_mode, serial_sel, link_state == port_select_pkg::LINK_SER};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= port_select_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= port_select_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			for (int i = 0; i < port_select_pkg::CHANNELS; i++) begin
				result[i] <= port_select_pkg::RESULT_RESET;
			end
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (mapped(aw_addr) || aw_addr == port_select_pkg::ADDR_STATUS) ?
					port_select_pkg::RESP_OKAY : port_select_pkg::RESP_SLVERR;
				if (mapped(aw_addr)) begin
					result[chan_of(aw_addr)] <= (result[chan_of(aw_addr)] & ~wmask) |
						(w_data[15:0] & wmask);
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= port_select_pkg::RESP_OKAY;
				if (mapped(s_axi_araddr)) begin
					s_axi_rdata <= {16'h0000, result[chan_of(s_axi_araddr)]};
				end else if (s_axi_araddr == port_select_pkg::ADDR_STATUS) begin
					s_axi_rdata <= status_word;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= port_select_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// link mode follows the interface strap, re-read between frames only
	always_comb begin
		case (link_state)
			port_select_pkg::LINK_IDLE: begin
				next_link_state = serial_sel ? port_select_pkg::LINK_SER : port_select_pkg::LINK_PAR;
			end
			port_select_pkg::LINK_PAR: begin
				next_link_state = (serial_sel && fs_n) ? port_select_pkg::LINK_IDLE : link_state;
			end
			port_select_pkg::LINK_SER: begin
				next_link_state = (!serial_sel && fs_n) ? port_select_pkg::LINK_IDLE : link_state;
			end
			default: begin
				next_link_state = port_select_pkg::LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_state <= port_select_pkg::LINK_IDLE;
			sclk_prev <= 1'b0;
			rd_prev <= 1'b1;
			fs_prev <= 1'b1;
		end else begin
			link_state <= next_link_state;
			sclk_prev <= serial_clock;
			rd_prev <= rd_n;
			fs_prev <= fs_n;
		end
	end

	// parallel read walk: chip select high restarts at channel A0
	always_ff @(posedge aclk) begin
		if (!aresetn || fs_n || link_state != port_select_pkg::LINK_PAR) begin
			read_index <= 3'h0;
			second_half <= 1'b0;
		end else if (rd_rise) begin
			if (byte_mode && !second_half) begin
				second_half <= 1'b1; // [R13]
			end else begin
				second_half <= 1'b0;
				read_index <= (read_index == port_select_pkg::LAST_CHANNEL) ? 3'h0 : 3'(read_index + 3'h1);
			end
		end
	end

	// serial streams: load at frame start, shift on serial clock fall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stream_a <= 48'h0000_0000_0000;
			stream_b <= 48'h0000_0000_0000;
			stream_c <= 48'h0000_0000_0000;
		end else if (link_state == port_select_pkg::LINK_SER && frame_start) begin
			stream_a <= {result[0], result[1], sel_c ? 16'h0000 : result[4]};
			stream_b <= {result[2], result[3], sel_c ? 16'h0000 : result[5]}; // [R11]
			stream_c <= {result[4], result[5], 16'h0000};
		end else if (link_state == port_select_pkg::LINK_SER && !fs_n && sclk_fall) begin
			stream_a <= {stream_a[46:0], chain_in_pair_a}; // [R3]
			stream_b <= {stream_b[46:0], chain_in_pair_b}; // [R4]
			stream_c <= {stream_c[46:0], chain_in_pair_c}; // [R5]
		end
	end

	// pin drive; strap-held lines 7:0 are driven back only during word-mode reads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			parallel_bus_line_out <= 16'h0000;
			parallel_bus_line_oe <= 16'h0000;
		end else if (link_state == port_select_pkg::LINK_SER) begin
			parallel_bus_line_out <= {5'h00, stream_c[47], stream_b[47], stream_a[47], 8'h00};
			parallel_bus_line_oe <= {5'h00, sel_c, sel_b, sel_a, 8'h00}; // [R6] [R7]
		end else if (par_read && byte_mode) begin
			parallel_bus_line_out <= {cur_byte, 8'h00}; // [R1] [R2]
			parallel_bus_line_oe <= port_select_pkg::OE_BYTE;
		end else if (par_read) begin
			parallel_bus_line_out <= cur_word; // [R8]
			parallel_bus_line_oe <= port_select_pkg::OE_WORD;
		end else begin
			parallel_bus_line_out <= 16'h0000;
			parallel_bus_line_oe <= 16'h0000;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	high_byte_first_a: assert property (par_read && byte_mode && byte_order_strap && !second_half
		|=> parallel_bus_line_out[15:8] == $past(cur_word[15:8])) // [R1]
		else $error("high byte not first");
	low_byte_first_a: assert property (par_read && byte_mode && !byte_order_strap && !second_half
		|=> parallel_bus_line_out[15:8] == $past(cur_word[7:0])) // [R2]
		else $error("low byte not first");
	chain_pair_a_a: assert property (link_state == port_select_pkg::LINK_SER && !fs_n && sclk_fall
		&& !frame_start |=> stream_a == {$past(stream_a[46:0]),
		$past(pins[port_select_pkg::LINE_CHAIN_A] && pins[port_select_pkg::LINE_CHAIN_EN])}) // [R3]
		else $error("pair a chain input wrong");
	chain_pair_b_a: assert property (link_state == port_select_pkg::LINK_SER && !fs_n && sclk_fall
		&& !frame_start && !(sel_b && chain_enable_strap) |=> !stream_b[0]) // [R4]
		else $error("pair b chain taken while disabled");
	chain_pair_c_a: assert property (link_state == port_select_pkg::LINK_SER && !fs_n && sclk_fall
		&& !frame_start && !(sel_c && chain_enable_strap) |=> !stream_c[0]) // [R5]
		else $error("pair c chain taken while disabled");
	pair_c_enable_a: assert property (link_state == port_select_pkg::LINK_SER
		|=> parallel_bus_line_oe[10] == $past(sel_c)) // [R6]
		else $error("pair c output enable wrong");
	pair_b_enable_a: assert property (link_state == port_select_pkg::LINK_SER
		|=> parallel_bus_line_oe[9] == $past(sel_b)) // [R7]
		else $error("pair b output enable wrong");
	word_drive_a: assert property (par_read && !byte_mode
		|=> parallel_bus_line_oe == port_select_pkg::OE_WORD
		&& parallel_bus_line_out == $past(cur_word)) // [R8]
		else $error("word read not driven");
	serial_quiet_a: assert property (link_state == port_select_pkg::LINK_SER
		|=> parallel_bus_line_oe[7:0] == 8'h00 && parallel_bus_line_oe[15:11] == 5'h00) // [R10]
		else $error("serial mode drives parallel lines");
	pair_c_merge_a: assert property (link_state == port_select_pkg::LINK_SER && frame_start && !sel_c
		|=> stream_b[15:0] == $past(result[5])) // [R11]
		else $error("pair c data missing on pair b");
	second_half_a: assert property (link_state == port_select_pkg::LINK_PAR && !fs_n && rd_rise
		&& byte_mode && !second_half |=> second_half && $stable(read_index)) // [R13]
		else $error("second half not presented");

	word_read_c: cover property (par_read && !byte_mode ##1 rd_rise);
	byte_pair_c: cover property (par_read && byte_mode && second_half);
	serial_frame_c: cover property (link_state == port_select_pkg::LINK_SER && frame_start);
	chain_shift_c: cover property (sclk_fall && chain_in_pair_a);
endmodule : adc_output_port_select

/* File: host_model.sv */
// host controller model: straps, parallel strobes, serial frames
`timescale 1ns/10ps
module host_model (
	input wire logic aclk,
	input wire logic [15:0] level,
	input wire logic [15:0] oe,
	output logic iface,
	output logic word_byte,
	output logic fs_n,
	output logic rd_n,
	output logic [15:0] drv
);
	initial begin
		iface = 1'b0;
		word_byte = 1'b0;
		fs_n = 1'b1;
		rd_n = 1'b1;
		drv = 16'h0001; // pair-a select held high
	end
	// straps move only between frames, strobes idle
	task automatic straps(input logic s, input logic wb, input logic [7:0] lines);
		@(posedge aclk);
		iface <= s;
		word_byte <= wb;
		drv <= {8'h00, lines | 8'h01};
		repeat (10) @(posedge aclk);
	endtask : straps
	task automatic sel(input logic v);
		@(posedge aclk);
		fs_n <= v;
		repeat (10) @(posedge aclk);
	endtask : sel
	// pins have no handshake: wait out the sync delay
	task automatic par_read(output logic [15:0] d, output logic [15:0] o);
		@(posedge aclk);
		rd_n <= 1'b0;
		repeat (8) @(posedge aclk);
		d = level;
		o = oe;
		rd_n <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask : par_read
	// clock of four high and four low cycles; each phase outlasts the sync delay
	task automatic ser_frame(output logic [51:0] a, output logic [51:0] b,
		output logic [51:0] c, output logic [2:0] o);
		@(posedge aclk);
		fs_n <= 1'b0;
		repeat (12) @(posedge aclk);
		o = oe[10:8];
		for (int i = 51; i >= 0; i--) begin
			drv[6] <= 1'b1; // host supplies shift clock
			repeat (4) @(posedge aclk);
			{c[i], b[i], a[i]} = level[10:8];
			drv[6] <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		fs_n <= 1'b1;
		repeat (10) @(posedge aclk);
	endtask : ser_frame
endmodule : host_model

/* File: testbench.sv */
// self-checking bench for the converter output port block
`timescale 1ns/10ps
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic iface, word_byte, fs_n, rd_n;
	logic [15:0] drv, bus_in, bus_out, oe;
	logic [15:0] res [6] = '{16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718, 16'h293A, 16'h4B5C};
	int mismatches = 0, n_compared = 0, cycles = 0;
	assign bus_in = (oe & bus_out) | (~oe & drv);
	always #50 aclk = ~aclk;
	adc_output_port_select dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .interface_type_strap(iface),
		.word_byte_strap(word_byte), .frame_select_n(fs_n), .read_strobe_n(rd_n),
		.parallel_bus_line_in(bus_in), .parallel_bus_line_out(bus_out),
		.parallel_bus_line_oe(oe));
	host_model host_u (.aclk(aclk), .level(bus_in), .oe(oe), .iface(iface),
		.word_byte(word_byte), .fs_n(fs_n), .rd_n(rd_n), .drv(drv));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk({62'h0, got}, {62'h0, exp});
	endtask : chk_resp
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 6; i++) begin
			axi_wr(8'(i * 4), {16'h0000, res[i]}, r);
			chk_resp(r, port_select_pkg::RESP_OKAY);
		end
		for (int i = 0; i < 6; i++) begin
			axi_rd(8'(i * 4), d, r);
			chk(d, {16'h0000, res[i]});
			chk_resp(r, port_select_pkg::RESP_OKAY);
		end
		axi_rd(8'h1C, d, r);
		chk_resp(r, port_select_pkg::RESP_SLVERR);
		chk(d, 32'h0000_0000);
		// idle straps: parallel, word mode, only pair-a select high
		axi_rd(port_select_pkg::ADDR_STATUS, d, r);
		chk(d, 32'h0000_0010);
		axi_wr(port_select_pkg::ADDR_STATUS, 32'h0000_FFFF, r);
		chk_resp(r, port_select_pkg::RESP_OKAY);
		$display("test regs done");
	endtask : t_regs
	task automatic t_word();
		logic [15:0] d, o;
		host_u.straps(1'b0, 1'b0, 8'h00);
		host_u.sel(1'b0);
		for (int i = 0; i < 6; i++) begin
			host_u.par_read(d, o);
			chk(d, res[i]);
			chk(o, port_select_pkg::OE_WORD);
		end
		host_u.sel(1'b1);
		$display("test word done");
	endtask : t_word
	// byte order strap rides on line 7 in byte mode
	task automatic t_byte(input logic hi);
		logic [15:0] d, o;
		host_u.straps(1'b0, 1'b1, {hi, 7'h00});
		host_u.sel(1'b0);
		for (int i = 0; i < 6; i++) begin
			host_u.par_read(d, o);
			chk(d[15:8], hi ? res[i][15:8] : res[i][7:0]);
			chk(o, port_select_pkg::OE_BYTE);
			host_u.par_read(d, o);
			chk(d[15:8], hi ? res[i][7:0] : res[i][15:8]);
		end
		host_u.sel(1'b1);
		$display("test byte done");
	endtask : t_byte
	// chain inputs all high, so four extra bits show the chain path
	task automatic t_ser(input logic sb, input logic sc, input logic ch);
		logic [51:0] a, b, c;
		logic [2:0] o;
		host_u.straps(1'b1, 1'b0, {ch, 4'b0111, sc, sb, 1'b1});
		host_u.ser_frame(a, b, c, o);
		chk(o, {sc, sb, 1'b1});
		chk(a, {res[0], res[1], sc ? 16'h0000 : res[4], {4{ch}}});
		if (sb) chk(b, {res[2], res[3], sc ? 16'h0000 : res[5], {4{ch}}});
		if (sc) chk(c, {res[4], res[5], 16'h0000, {4{ch}}});
		$display("test serial done");
	endtask : t_ser
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		t_regs();
		t_word();
		t_byte(1'b1);
		t_byte(1'b0);
		t_ser(1'b1, 1'b1, 1'b1);
		t_ser(1'b1, 1'b0, 1'b1);
		t_ser(1'b0, 1'b1, 1'b0);
		final_report();
	end
endmodule : testbench
